// ===== rtl/envsup.sv
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "envsup_regs.svh"

// What this block does
// [RULE1] thermal levels encoded 1, -1, 0
// [RULE2] thermal message on leaving or reentering range
// [RULE3] setting 1 always presents levels 1,-1,0
// [RULE4] setting 0 presents only in guard window
// [RULE5] level 2/-2 always, then shutdown
// [RULE6] undervoltage warning within margin above threshold
// [RULE7] undervoltage warning once per approach
// [RULE8] one undervoltage shutdown message, then silence
// [RULE9] supply messages need no enable
// [RULE10] host lowers undervoltage threshold by offset
// [RULE11] overvoltage warning within margin below threshold
// [RULE12] overvoltage warning once per approach
// [RULE13] one overvoltage shutdown message, then silence
// [RULE14] drop to class 8 at 75 degC
// [RULE15] restore only at 70 degC or below
// [RULE16] block return for one minute
// [RULE17] power save mode 2 idles both uarts
// [RULE18] no sleep while usb active; code blocks only entry, sleep already set is kept
// [RULE19] host keeps usb supply sense enabled
// [RULE20] power reduction on by default, host changeable
// [RULE21] request-to-send falling edge wakes, clear-to-send ready
// [RULE22] four configurable temperature thresholds
module envsup
  import envsup_pkg::*;
#(
  parameter int unsigned GUARD_CYC = `ES_GUARD_S * `ES_CLK_HZ, // guard window
  parameter int unsigned BLOCK_CYC = `ES_BLOCK_S * `ES_CLK_HZ  // class lock-out
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // sensors (already averaged, from other clock domains)
  input  wire logic [15:0] temp_i,
  input  wire logic [15:0] vsup_i,
  input  wire logic        tx_multislot_i,
  input  wire logic        usb_supply_sense_i,
  input  wire logic        usb_suspend_i,
  input  wire logic        host_request_to_send_i,
  // outputs
  output logic             msg_valid_o,
  output logic      [6:0]  msg_o,
  output logic             shutdown_o,
  output logic             class_reduced_o,
  output logic             pwr_reduce_o,
  output logic             uart_sleep_o,
  output logic             module_clear_to_send_o
);

  // all state in one record
  typedef struct packed {
    logic [15:0]       t1, t2, v1, v2;       // two-stage synchronisers
    logic [2:0]        u1, u2;               // usb sense, suspend, rts
    logic              rts_d;                // rts last value (from stage 2)
    logic [31:0]       ctrl_r;
    logic [15:0]       near_hi_r, at_hi_r, near_lo_r, at_lo_r;
    logic [15:0]       uv_r, ov_r, uv_ofs_r;
    logic [31:0]       guard_cnt_r;
    logic              guard_r;
    logic [31:0]       blk_cnt_r;
    logic              cls_red_r;
    logic signed [2:0] lvl_r;
    logic              uv_arm_r, ov_arm_r;
    es_state_e         st_r;
    logic              sleep_r, cts_r;
    logic              mv_r;
    logic [6:0]        msg_r;
    logic [6:0]        last_msg_r;
    logic [31:0]       rd_r;
    logic              ack_r;
    logic [1:0]        fill_r;               // edges seen since reset, saturates at 2
  } es_st_s;

  es_st_s q_r, q_nxt;

  // signed compare of readings
  function automatic logic sge(input logic [15:0] a, input logic [15:0] b);
    sge = $signed(a) >= $signed(b);
  endfunction

  // pack a message record into the output word
  function automatic logic [6:0] pk(input es_msg_e k, input logic signed [2:0] l);
    es_msg_s m;
    m.kind  = k;
    m.level = l;
    pk = m;
  endfunction

  logic signed [2:0] lvl_now;
  logic [15:0]       uv_eff;
  logic              wb_hit;

  // next-state logic
  always_comb begin
    q_nxt = q_r;
    q_nxt.t1 = temp_i;
    q_nxt.t2 = q_r.t1;
    q_nxt.v1 = vsup_i;
    q_nxt.v2 = q_r.v1;
    q_nxt.u1 = {usb_supply_sense_i, usb_suspend_i, host_request_to_send_i};
    q_nxt.u2 = q_r.u1;
    q_nxt.rts_d = q_r.u2[0];
    q_nxt.mv_r = 1'b0;
    q_nxt.ack_r = 1'b0;
    // temperature and supply synchronisers hold zeros out of reset; a zero supply reading would
    // look like undervoltage, so judge nothing until real readings arrive
    if (!q_r.fill_r[1]) begin
      q_nxt.fill_r = q_r.fill_r + 2'b01;
    end
    // threshold after host offset, floored at zero
    uv_eff = (q_r.uv_r > q_r.uv_ofs_r) ? q_r.uv_r - q_r.uv_ofs_r : 16'h0000; // RULE10
    // level from four thresholds
    if (sge(q_r.t2, q_r.at_hi_r)) begin // RULE22
      lvl_now = 3'sd2; // RULE1
    end else if (sge(q_r.at_lo_r, q_r.t2)) begin
      lvl_now = -3'sd2;
    end else if (sge(q_r.t2, q_r.near_hi_r)) begin
      lvl_now = 3'sd1;
    end else if (sge(q_r.near_lo_r, q_r.t2)) begin
      lvl_now = -3'sd1;
    end else begin
      lvl_now = 3'sd0;
    end
    // guard window counts down once after reset
    if (q_r.guard_cnt_r != 32'h0000_0000) begin
      q_nxt.guard_cnt_r = q_r.guard_cnt_r - 32'h0000_0001;
    end else begin
      q_nxt.guard_r = 1'b0; // RULE4
    end
    // supervision, only while running; shutdown silences everything
    if (q_r.st_r == ES_ST_RUN && q_r.fill_r[1]) begin
      q_nxt.lvl_r = lvl_now;
      if (lvl_now == 3'sd2 || lvl_now == -3'sd2) begin
        q_nxt.mv_r = 1'b1; // RULE5
        q_nxt.msg_r = pk(ES_MSG_THERM, lvl_now);
        q_nxt.st_r = ES_ST_SHDN;
      end else if (q_r.v2 < uv_eff) begin
        q_nxt.mv_r = 1'b1; // RULE8 RULE9
        q_nxt.msg_r = pk(ES_MSG_UV_SHDN, 3'sd0);
        q_nxt.st_r = ES_ST_SHDN;
      end else if (q_r.v2 > q_r.ov_r) begin
        q_nxt.mv_r = 1'b1; // RULE13
        q_nxt.msg_r = pk(ES_MSG_OV_SHDN, 3'sd0);
        q_nxt.st_r = ES_ST_SHDN;
      end else if (lvl_now != q_r.lvl_r && (q_r.ctrl_r[`ES_CTRL_PRES] || q_r.guard_r)) begin
        q_nxt.mv_r = 1'b1; // RULE2 RULE3
        q_nxt.msg_r = pk(ES_MSG_THERM, lvl_now);
      end else if (q_r.uv_arm_r && q_r.v2 <= uv_eff + `ES_MARGIN_MV) begin
        q_nxt.mv_r = 1'b1; // RULE6
        q_nxt.msg_r = pk(ES_MSG_UV_WARN, 3'sd0);
        q_nxt.uv_arm_r = 1'b0; // RULE7
      end else if (q_r.ov_arm_r && q_r.v2 + `ES_MARGIN_MV >= q_r.ov_r) begin
        q_nxt.mv_r = 1'b1; // RULE11
        q_nxt.msg_r = pk(ES_MSG_OV_WARN, 3'sd0);
        q_nxt.ov_arm_r = 1'b0; // RULE12
      end
      // re-arm once clear of the warning band
      if (q_r.v2 > uv_eff + `ES_MARGIN_MV) begin
        q_nxt.uv_arm_r = 1'b1; // RULE7
      end
      if (q_r.v2 + `ES_MARGIN_MV < q_r.ov_r) begin
        q_nxt.ov_arm_r = 1'b1; // RULE12
      end
    end
    if (q_nxt.mv_r) begin
      q_nxt.last_msg_r = q_nxt.msg_r;
    end
    // multislot class with hysteresis and lock-out
    if (q_r.blk_cnt_r != 32'h0000_0000) begin
      q_nxt.blk_cnt_r = q_r.blk_cnt_r - 32'h0000_0001;
    end
    if (!q_r.cls_red_r && tx_multislot_i && sge(q_r.t2, `ES_CLS_DOWN_C)) begin
      q_nxt.cls_red_r = 1'b1; // RULE14
      q_nxt.blk_cnt_r = BLOCK_CYC; // RULE16
    end else if (q_r.cls_red_r && q_r.blk_cnt_r == 32'h0000_0000 && sge(`ES_CLS_UP_C, q_r.t2)) begin
      q_nxt.cls_red_r = 1'b0; // RULE15
    end
    // sleep gating: mode 2 selected and usb absent or suspended
    if (q_r.sleep_r && q_r.rts_d && !q_r.u2[0]) begin
      q_nxt.sleep_r = 1'b0; // RULE21
      q_nxt.cts_r = 1'b1;
    end else if (q_r.ctrl_r[`ES_CTRL_PSAVE1] && !q_r.ctrl_r[`ES_CTRL_PSAVE0]
                 && (!q_r.u2[2] || q_r.u2[1])
                 && q_r.u2[0]) begin // an asserted request line keeps the uarts awake
      q_nxt.sleep_r = 1'b1; // RULE17 RULE18 RULE19
      q_nxt.cts_r = 1'b0;
    end else if (!q_r.sleep_r) begin
      q_nxt.cts_r = 1'b1;
    end
    // wishbone slave, one-cycle answer
    wb_hit = wb_cyc_i && wb_stb_i && !q_r.ack_r;
    if (wb_hit) begin
      q_nxt.ack_r = 1'b1;
      q_nxt.rd_r = 32'h0000_0000;
      if (wb_adr_i == `ES_OFF_CTRL) begin
        q_nxt.rd_r = q_r.ctrl_r;
        if (wb_we_i && wb_sel_i[0]) begin
          q_nxt.ctrl_r = {24'h00_0000, wb_dat_i[7:0]};
          q_nxt.sleep_r = 1'b0; // mode change wakes; gate re-evaluates next cycle
        end
      end else if (wb_adr_i == `ES_OFF_TEMP_HI) begin
        q_nxt.rd_r = {q_r.at_hi_r, q_r.near_hi_r};
        if (wb_we_i) begin
          if (wb_sel_i[1:0] == 2'b11) q_nxt.near_hi_r = wb_dat_i[15:0];
          if (wb_sel_i[3:2] == 2'b11) q_nxt.at_hi_r = wb_dat_i[31:16];
        end
      end else if (wb_adr_i == `ES_OFF_TEMP_LO) begin
        q_nxt.rd_r = {q_r.at_lo_r, q_r.near_lo_r};
        if (wb_we_i) begin
          if (wb_sel_i[1:0] == 2'b11) q_nxt.near_lo_r = wb_dat_i[15:0];
          if (wb_sel_i[3:2] == 2'b11) q_nxt.at_lo_r = wb_dat_i[31:16];
        end
      end else if (wb_adr_i == `ES_OFF_UV) begin
        q_nxt.rd_r = {q_r.uv_ofs_r, q_r.uv_r};
        if (wb_we_i) begin
          if (wb_sel_i[1:0] == 2'b11) q_nxt.uv_r = wb_dat_i[15:0];
          if (wb_sel_i[3:2] == 2'b11) q_nxt.uv_ofs_r = wb_dat_i[31:16]; // RULE10
        end
      end else if (wb_adr_i == `ES_OFF_OV) begin
        q_nxt.rd_r = {16'h0000, q_r.ov_r};
        if (wb_we_i && wb_sel_i[1:0] == 2'b11) q_nxt.ov_r = wb_dat_i[15:0];
      end else if (wb_adr_i == `ES_OFF_STATUS) begin
        q_nxt.rd_r = {22'h00_0000, q_r.cts_r, q_r.sleep_r, q_r.cls_red_r, q_r.guard_r,
                      q_r.st_r == ES_ST_SHDN, q_r.lvl_r, q_r.uv_arm_r, q_r.ov_arm_r};
      end else if (wb_adr_i == `ES_OFF_MSG) begin
        q_nxt.rd_r = {25'h000_0000, q_r.last_msg_r};
      end else if (wb_adr_i == `ES_OFF_SENSE) begin
        q_nxt.rd_r = {q_r.v2, q_r.t2};
      end
    end
  end

  // register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;
      // sync stages rest at the idle pin levels so no false wake edge follows reset
      q_r.u1 <= 3'b001;
      q_r.u2 <= 3'b001;
      q_r.rts_d <= 1'b1;
      q_r.ctrl_r <= `ES_CTRL_RST; // RULE20
      q_r.near_hi_r <= `ES_NEAR_HI_RST;
      q_r.at_hi_r <= `ES_AT_HI_RST;
      q_r.near_lo_r <= `ES_NEAR_LO_RST;
      q_r.at_lo_r <= `ES_AT_LO_RST;
      q_r.uv_r <= `ES_UV_RST;
      q_r.ov_r <= `ES_OV_RST;
      q_r.uv_ofs_r <= `ES_UV_OFS_RST;
      q_r.guard_cnt_r <= GUARD_CYC;
      q_r.guard_r <= 1'b1;
      q_r.uv_arm_r <= 1'b1;
      q_r.ov_arm_r <= 1'b1;
      q_r.st_r <= ES_ST_RUN;
      q_r.cts_r <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from flops
  assign wb_dat_o = q_r.rd_r;
  assign wb_ack_o = q_r.ack_r;
  assign msg_valid_o = q_r.mv_r;
  assign msg_o = q_r.msg_r;
  assign shutdown_o = q_r.st_r == ES_ST_SHDN;
  assign class_reduced_o = q_r.cls_red_r;
  assign pwr_reduce_o = q_r.ctrl_r[`ES_CTRL_PWRRED]; // RULE20
  assign uart_sleep_o = q_r.sleep_r;
  assign module_clear_to_send_o = q_r.cts_r;

  // assertions
  property p_shdn_stays;
    @(posedge clk_i) disable iff (rst_i) shutdown_o |=> shutdown_o && !msg_valid_o;
  endproperty
  a_shdn_stays: assert property (p_shdn_stays) else $error("message after shutdown"); // RULE8

  property p_crit_shdn;
    @(posedge clk_i) disable iff (rst_i)
      (!shutdown_o && (lvl_now == 3'sd2 || lvl_now == -3'sd2)) |=> shutdown_o && msg_valid_o;
  endproperty
  a_crit_shdn: assert property (p_crit_shdn) else $error("critical level without shutdown"); // RULE5

  property p_no_sleep_usb;
    @(posedge clk_i) disable iff (rst_i) (q_r.u2[2] && !q_r.u2[1] && !uart_sleep_o) |=> !uart_sleep_o;
  endproperty
  a_no_sleep_usb: assert property (p_no_sleep_usb) else $error("sleep with usb active"); // RULE18

  property p_quiet_guard;
    @(posedge clk_i) disable iff (rst_i)
      (msg_valid_o && msg_o[6:3] == ES_MSG_THERM && msg_o[2:0] != 3'sd2 && msg_o[2:0] != 3'b110)
      |-> ($past(q_r.ctrl_r[`ES_CTRL_PRES]) || $past(q_r.guard_r));
  endproperty
  a_quiet_guard: assert property (p_quiet_guard) else $error("thermal message outside window"); // RULE4

  property p_cls_block;
    @(posedge clk_i) disable iff (rst_i) $rose(class_reduced_o) |-> ##1 class_reduced_o [*8];
  endproperty
  a_cls_block: assert property (p_cls_block) else $error("class restored too soon"); // RULE16

  property p_uv_once;
    @(posedge clk_i) disable iff (rst_i)
      (msg_valid_o && msg_o[6:3] == ES_MSG_UV_WARN) |-> !q_r.uv_arm_r;
  endproperty
  a_uv_once: assert property (p_uv_once) else $error("undervoltage warning re-armed early"); // RULE7

  property p_ov_once;
    @(posedge clk_i) disable iff (rst_i)
      (msg_valid_o && msg_o[6:3] == ES_MSG_OV_WARN) |-> !q_r.ov_arm_r;
  endproperty
  a_ov_once: assert property (p_ov_once) else $error("overvoltage warning re-armed early"); // RULE12

  property p_ack;
    @(posedge clk_i) disable iff (rst_i) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing wrong");

  // class steps, sleep and wake, and message consistency
  property p_cls_down;
    @(posedge clk_i) disable iff (rst_i)
      (!class_reduced_o && tx_multislot_i && $signed(q_r.t2) >= $signed(`ES_CLS_DOWN_C)) |=> class_reduced_o;
  endproperty
  a_cls_down: assert property (p_cls_down) else $error("class not reduced when hot"); // RULE14

  property p_cls_hold;
    @(posedge clk_i) disable iff (rst_i)
      (class_reduced_o && $signed(q_r.t2) > $signed(`ES_CLS_UP_C)) |=> class_reduced_o;
  endproperty
  a_cls_hold: assert property (p_cls_hold) else $error("class restored above hysteresis point"); // RULE15

  property p_wake;
    @(posedge clk_i) disable iff (rst_i)
      (uart_sleep_o && q_r.rts_d && !q_r.u2[0]) |=> !uart_sleep_o && module_clear_to_send_o;
  endproperty
  a_wake: assert property (p_wake) else $error("request line did not wake"); // RULE21

  property p_sleep_cts;
    @(posedge clk_i) disable iff (rst_i) uart_sleep_o |-> !module_clear_to_send_o;
  endproperty
  a_sleep_cts: assert property (p_sleep_cts) else $error("ready shown while asleep"); // RULE17

  property p_shdn_msg;
    @(posedge clk_i) disable iff (rst_i) $rose(shutdown_o) |-> msg_valid_o;
  endproperty
  a_shdn_msg: assert property (p_shdn_msg) else $error("shutdown without its message"); // RULE8

  property p_therm_lvl;
    @(posedge clk_i) disable iff (rst_i)
      (msg_valid_o && msg_o[6:3] == ES_MSG_THERM) |-> msg_o[2:0] == q_r.lvl_r;
  endproperty
  a_therm_lvl: assert property (p_therm_lvl) else $error("alert level differs from tracked level"); // RULE1

  c_shdn:  cover property (@(posedge clk_i) disable iff (rst_i) $rose(shutdown_o));
  c_cls:   cover property (@(posedge clk_i) disable iff (rst_i) $fell(class_reduced_o));
  c_sleep: cover property (@(posedge clk_i) disable iff (rst_i) $fell(uart_sleep_o));
  c_uv_warn: cover property (@(posedge clk_i) disable iff (rst_i) msg_valid_o && msg_o[6:3] == ES_MSG_UV_WARN);
  c_wake:  cover property (@(posedge clk_i) disable iff (rst_i) $rose(module_clear_to_send_o));

endmodule
`default_nettype wire

// ===== rtl/envsup_regs.svh
`ifndef ENVSUP_REGS_SVH
`define ENVSUP_REGS_SVH
// register byte offsets (word aligned)
`define ES_OFF_CTRL      8'h00
`define ES_OFF_TEMP_HI   8'h04
`define ES_OFF_TEMP_LO   8'h08
`define ES_OFF_UV        8'h0C
`define ES_OFF_OV        8'h10
`define ES_OFF_STATUS    8'h14
`define ES_OFF_MSG       8'h18
`define ES_OFF_SENSE     8'h1C
// control fields
`define ES_CTRL_PRES     0
`define ES_CTRL_PSAVE0   1
`define ES_CTRL_PSAVE1   2
`define ES_CTRL_PWRRED   3
`define ES_CTRL_RST      32'h0000_0008
// default thresholds (temperature in 1/1 degC, voltage in mV)
`define ES_NEAR_HI_RST   16'h0050
`define ES_AT_HI_RST     16'h005A
`define ES_NEAR_LO_RST   16'hFFE7
`define ES_AT_LO_RST     16'hFFE2
`define ES_UV_RST        16'h0CE4
`define ES_OV_RST        16'h1194
`define ES_UV_OFS_RST    16'h0000
`define ES_MARGIN_MV     16'h0032
`define ES_CLS_DOWN_C    16'h004B
`define ES_CLS_UP_C      16'h0046
// timing
`define ES_CLK_HZ        20000000
`define ES_GUARD_S       120
`define ES_BLOCK_S       60
`endif

// ===== rtl/envsup_pkg.sv
package envsup_pkg;
  // message kinds posted to the host
  typedef enum logic [3:0] {
    ES_MSG_NONE    = 4'h0,
    ES_MSG_THERM   = 4'h1,
    ES_MSG_UV_WARN = 4'h2,
    ES_MSG_UV_SHDN = 4'h3,
    ES_MSG_OV_WARN = 4'h4,
    ES_MSG_OV_SHDN = 4'h5
  } es_msg_e;
  // supervisor state
  typedef enum logic [1:0] {
    ES_ST_RUN  = 2'b00,
    ES_ST_SHDN = 2'b01
  } es_state_e;
  // wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } es_wb_req_s;
  // message record
  typedef struct packed {
    es_msg_e           kind;
    logic signed [2:0] level;
  } es_msg_s;
endpackage

// ===== testbench/envsup_host.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the host application: logs alerts and owns the wake line
module envsup_host (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // alert stream from the supervisor
  input  wire logic       msg_valid_i,
  input  wire logic [6:0] msg_i,
  // flow-control line, idles high when inactive
  output logic            host_request_to_send_o
);
  int         count = 0;     // alerts seen since reset
  logic [6:0] last  = 7'h00; // newest alert
  initial host_request_to_send_o = 1'b1;
  // the valid pulse lasts one cycle, so every edge is looked at
  always @(posedge clk_i) begin
    if (rst_i) begin
      count <= 0;
    end else if (msg_valid_i === 1'b1) begin
      count <= count + 1;
      last  <= msg_i;
    end
  end
  // falling step wakes the module; held four cycles so the synchroniser surely sees it
  task automatic wake();
    host_request_to_send_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    host_request_to_send_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== testbench/envsup_tb.sv
`timescale 1ns/1ps
`default_nettype none
module envsup_tb;
  import envsup_pkg::*;
  // stimulus, all given a value at time zero
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  es_wb_req_s  req       = '0;
  logic [15:0] temp      = 16'h0019; // 25 degC
  logic [15:0] vsup      = 16'h0ED8; // 3800 mV, well inside the band
  logic        multislot = 1'b0;
  logic        usb_sense = 1'b1;     // sense kept enabled throughout
  logic        usb_susp  = 1'b0;
  // observed outputs
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic        wb_ack_o;
  logic        msg_valid_o;
  logic [6:0]  msg_o;
  logic        shutdown_o;
  logic        class_reduced_o;
  logic        pwr_reduce_o;
  logic        uart_sleep_o;
  logic        cts;
  wire         rts;
  int          miscompares     = 0;
  int          samples_checked = 0;
  int          cycles          = 0;
  int          ec              = 0; // alerts expected so far
  int          n;

  always #25 clk_i = ~clk_i;

  // short guard and lock-out so the run stays brief
  envsup #(.GUARD_CYC(200), .BLOCK_CYC(50)) dut (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr),
    .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .temp_i(temp), .vsup_i(vsup), .tx_multislot_i(multislot),
    .usb_supply_sense_i(usb_sense), .usb_suspend_i(usb_susp), .host_request_to_send_i(rts),
    .msg_valid_o(msg_valid_o), .msg_o(msg_o), .shutdown_o(shutdown_o),
    .class_reduced_o(class_reduced_o), .pwr_reduce_o(pwr_reduce_o),
    .uart_sleep_o(uart_sleep_o), .module_clear_to_send_o(cts)
  );
  envsup_host host (
    .clk_i(clk_i), .rst_i(rst_i), .msg_valid_i(msg_valid_o), .msg_i(msg_o),
    .host_request_to_send_o(rts)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // cut a hang short; the whole run needs about 830 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 4000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // one classic cycle; waits for ack, then releases for one cycle
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1); // a lost answer is ended by the bench timeout
    q = wb_dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask

  // sensor steps leave room for sync plus decision
  task automatic set_t(input logic [15:0] t);
    temp <= t;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic set_v(input logic [15:0] v);
    vsup <= v;
    repeat (8) @(posedge clk_i);
  endtask

  // inc new alerts expected; mk selects the compared bits of the newest
  task automatic msgs(input int inc, input logic [6:0] m, input logic [6:0] mk);
    ec = ec + inc;
    chk(32'(host.count), 32'(ec));
    if (inc != 0) chk({25'h0, host.last & mk}, {25'h0, m & mk});
  endtask

  task automatic do_rst();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    ec = 0;
  endtask

  initial begin
    do_rst();
    xfer(1'b0, 8'h00, 32'h0, rd); chk(rd, 32'h0000_0008);
    chk(32'(pwr_reduce_o), 32'h1);
    xfer(1'b0, 8'h04, 32'h0, rd); chk(rd, 32'h005A_0050);
    xfer(1'b0, 8'h08, 32'h0, rd); chk(rd, 32'hFFE2_FFE7);
    xfer(1'b0, 8'h10, 32'h0, rd); chk(rd, 32'h0000_1194);
    xfer(1'b0, 8'h1C, 32'h0, rd); chk(rd, 32'h0ED8_0019);
    xfer(1'b0, 8'h40, 32'h0, rd); chk(rd, 32'h0);
    xfer(1'b1, 8'h00, 32'h0, rd); chk(32'(pwr_reduce_o), 32'h0);
    xfer(1'b1, 8'h00, 32'h8, rd);
    // inside and after the guard window with default presentation, then with presentation on
    set_t(16'h0055); msgs(1, 7'h09, 7'h7F);
    set_t(16'h0019); msgs(1, 7'h08, 7'h7F);
    set_t(16'hFFE5); msgs(1, 7'h0F, 7'h7F);
    set_t(16'h0019); msgs(1, 7'h08, 7'h7F);
    repeat (200) @(posedge clk_i);
    set_t(16'h0055); msgs(0, 7'h00, 7'h7F);
    xfer(1'b1, 8'h00, 32'h9, rd);
    set_t(16'hFFE5); msgs(1, 7'h0F, 7'h7F);
    set_t(16'h0019); msgs(1, 7'h08, 7'h7F);
    // slot class step-down and hysteresis
    multislot <= 1'b1;
    set_t(16'h004B); chk(32'(class_reduced_o), 32'h1);
    set_t(16'h0048); repeat (60) @(posedge clk_i); chk(32'(class_reduced_o), 32'h1);
    set_t(16'h0046); chk(32'(class_reduced_o), 32'h0);
    set_t(16'h004B); set_t(16'h0046); chk(32'(class_reduced_o), 32'h1);
    repeat (50) @(posedge clk_i); chk(32'(class_reduced_o), 32'h0);
    multislot <= 1'b0;
    // sleep gating and wake through the flow-control line
    xfer(1'b1, 8'h00, 32'hD, rd); repeat (8) @(posedge clk_i);
    chk(32'(uart_sleep_o), 32'h0);
    usb_susp <= 1'b1; repeat (8) @(posedge clk_i);
    chk(32'(uart_sleep_o), 32'h1);
    chk(32'(cts), 32'h0);
    fork host.wake(); join_none
    for (n = 0; n < 10 && cts !== 1'b1; n++) @(posedge clk_i);
    chk(32'(cts), 32'h1);
    @(posedge clk_i); chk(32'(uart_sleep_o), 32'h0);
    repeat (6) @(posedge clk_i);
    usb_susp <= 1'b0;
    xfer(1'b1, 8'h00, 32'h8, rd);
    // supply warnings with presentation off
    set_v(16'h0D0C); msgs(1, 7'h10, 7'h78);
    set_v(16'h0D02); msgs(0, 7'h00, 7'h78);
    set_v(16'h0ED8); set_v(16'h0D0C); msgs(1, 7'h10, 7'h78);
    xfer(1'b1, 8'h0C, 32'h0064_0CE4, rd);
    set_v(16'h0CA8); msgs(1, 7'h10, 7'h78);
    set_v(16'h116C); msgs(1, 7'h20, 7'h78);
    set_v(16'h1176); msgs(0, 7'h00, 7'h78);
    set_v(16'h11F8); msgs(1, 7'h28, 7'h78);
    chk(32'(shutdown_o), 32'h1);
    xfer(1'b0, 8'h18, 32'h0, rd); chk(rd, 32'h0000_0028);
    set_t(16'h005F); msgs(0, 7'h00, 7'h78);
    // undervoltage shutdown after a fresh reset
    set_t(16'h0019); set_v(16'h0ED8); do_rst();
    set_v(16'h0C80); msgs(1, 7'h18, 7'h78);
    chk(32'(shutdown_o), 32'h1);
    set_v(16'h0ED8); msgs(0, 7'h00, 7'h78);
    // critical cold with presentation off and the guard expired
    do_rst();
    repeat (220) @(posedge clk_i);
    set_t(16'hFFE1); msgs(1, 7'h0E, 7'h7F);
    chk(32'(shutdown_o), 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
